// file: bench/adrd_host.sv
/*
 * host side of the two-wire readout: drives the shift clock, samples the pin.
 * assumes clk_i is the converter clock and the device answers within two cycles.
 */
module adrd_host (
	input wire logic clk_i,
	input wire logic data_i,
	output logic shift_clk_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// idle level
	initial shift_clk_o = 1'b0;
	// ==========================================
	// pulses and reads
	task automatic set_level(input logic v);
		@(negedge clk_i) shift_clk_o = v;
	endtask
	task automatic pulse(output logic b);
		@(negedge clk_i) shift_clk_o = 1'b1;
		repeat (2) @(negedge clk_i);
		b = data_i;
		@(negedge clk_i) shift_clk_o = 1'b0;
	endtask
	task automatic read(input int n, output logic [23:0] w);
		logic b;
		w = '0;
		for (int i = 0; i < n; i++) begin
			pulse(b);
			if (i < 24) w = {w[22:0], b};
		end
	endtask
endmodule // adrd_host

// file: bench/tb_adrd_port.sv
/*
 * self-checking bench for the ready/data serial port.
 * assumes adrd_defs.svh on the include path and a shortened conversion period.
 */
`include "adrd_defs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_adrd_port;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEC = 4;
	localparam int SLP = 4;
	localparam int PER = DEC * `ADRD_MOD_DIV;
	localparam int NROW = 7;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic shift_clk, pin, sleeping, calibrating, mod_phase, b, mp;
	logic signed [31:0] sample = '0;
	logic [23:0] word;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	int tlast = 0;
	int gap, n;
	logic [31:0] rows_in [NROW] = '{32'h0000_0000, 32'h0000_0001, 32'hFFFF_FFFF,
		32'h007F_FFFF, 32'hFF80_0000, 32'h1000_0000, 32'hC000_0000};
	logic [23:0] rows_exp [NROW] = '{24'h00_0000, 24'h00_0001, 24'hFF_FFFF,
		24'h7F_FFFF, 24'h80_0000, `ADRD_FULL_POS, `ADRD_FULL_NEG};
	// ==========================================
	// clock, design and host
	always #2 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	adrd_port #(.DECIM(DEC), .SLEEP_HOLD(SLP)) u_dut (.clk_i(clk), .rst_n_i(rst_n),
		.ce_i(ce), .shift_clk_i(shift_clk), .sample_i(sample), .ready_data_out_o(pin),
		.sleeping_o(sleeping), .calibrating_o(calibrating), .mod_phase_o(mod_phase));
	adrd_host u_host (.clk_i(clk), .data_i(pin), .shift_clk_o(shift_clk));
	// ==========================================
	// helpers
	task automatic wait_rdy(output int k);
		k = 0;
		while (pin !== 1'b0 && k < 4 * PER) begin
			@(negedge clk);
			k++;
		end
		gap = cyc - tlast;
		tlast = cyc;
	endtask
	task automatic report_and_stop;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (40 * PER) @(posedge clk);
		fails++;
		report_and_stop();
	end
	// ==========================================
	// tests
	initial begin
		repeat (3) @(negedge clk);
		`CHK(pin, 1'b1)
		`CHK(calibrating, 1'b1)
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		wait_rdy(n);
		`CHK(n inside {[2 * PER - 8:2 * PER + 24]}, 1'b1)
		`CHK(calibrating, 1'b0)
		$display("test power_up done");
		sample = rows_in[0];
		u_host.read(25, word);
		for (int i = 1; i <= NROW; i++) begin
			wait_rdy(n);
			`CHK(pin, 1'b0)
			`CHK(gap, PER)
			if (i < NROW) sample = rows_in[i];
			u_host.read(25, word);
			`CHK(word, rows_exp[i - 1])
			`CHK(pin, 1'b1)
		end
		$display("test rows done");
		wait_rdy(n);
		u_host.read(24, word);
		`CHK(word, rows_exp[NROW - 1])
		repeat (20) @(negedge clk);
		`CHK(pin, rows_exp[NROW - 1][0])
		u_host.pulse(b);
		`CHK(pin, 1'b1)
		u_host.pulse(b);
		repeat (4) @(negedge clk);
		`CHK(calibrating, 1'b1)
		wait_rdy(n);
		`CHK(n inside {[2 * PER - 24:2 * PER + 24]}, 1'b1)
		`CHK(calibrating, 1'b0)
		$display("test hold_and_calibrate done");
		n = 0;
		mp = mod_phase;
		repeat (PER) begin
			@(negedge clk);
			if (mod_phase === 1'b1 && mp === 1'b0) n++;
			mp = mod_phase;
		end
		`CHK(n, DEC)
		$display("test modulator done");
		wait_rdy(n);
		u_host.pulse(b);
		`CHK(b, rows_exp[NROW - 1][23])
		u_host.set_level(1'b1);
		repeat (SLP + 8) @(negedge clk);
		`CHK(sleeping, 1'b1)
		`CHK(pin, 1'b1)
		u_host.set_level(1'b0);
		repeat (4) @(negedge clk);
		`CHK(sleeping, 1'b0)
		wait_rdy(n);
		`CHK(n inside {[PER - 24:PER + 24]}, 1'b1)
		$display("test sleep done");
		u_host.read(25, word);
		ce = 1'b0;
		repeat (100) @(negedge clk);
		ce = 1'b1;
		wait_rdy(n);
		`CHK(gap, PER + 100)
		$display("test clock_enable done");
		u_host.read(24, word);
		`CHK(word, rows_exp[NROW - 1])
		u_host.set_level(1'b1);
		repeat (SLP + 8) @(negedge clk);
		`CHK(sleeping, 1'b1)
		`CHK(pin, 1'b1)
		u_host.set_level(1'b0);
		repeat (4) @(negedge clk);
		`CHK(calibrating, 1'b1)
		wait_rdy(n);
		`CHK(n inside {[2 * PER - 24:2 * PER + 24]}, 1'b1)
		`CHK(calibrating, 1'b0)
		$display("test sleep_calibrate done");
		report_and_stop();
	end
endmodule // tb_adrd_port

// file: hw/adrd_port.sv
/*
 * conversion timing, calibration, sleep and two-wire readout.
 * assumes shift_clk_i is already synchronous to clk_i; clk_i free-running.
 */
`include "adrd_defs.svh"

// Overview of operation
// - pin goes low when a fresh result is ready.
// - first shift clock rise after ready presents the result msb.
// - rises 2 through 24 each shift out the next lower bit.
// - the 25th rise forces the pin high until next ready.
// - at 2.4576 MHz clock results come at 15 per second.
// - result rate scales directly with the system clock.
// - modulator cycle repeats every 128 system clocks.
// - ready falling edge marks the start of the next conversion.
// - each result is settled after one conversion cycle.
// - power-up runs self-calibration, then signals first result.
// - result is 24-bit two's complement, clipped at full scale.
// - falling edge of 26th clock starts a calibration; ready ends it.
// - shift clock held high after ready sleeps; low wakes.
module adrd_port #(
	parameter int RESULT_W = `ADRD_RESULT_W,
	parameter int DECIM = `ADRD_DECIM,
	parameter int SLEEP_HOLD = `ADRD_SLEEP_HOLD
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic shift_clk_i,
	input wire logic signed [31:0] sample_i,
	output logic ready_data_out_o,
	output logic sleeping_o,
	output logic calibrating_o,
	output logic mod_phase_o
);
	// =========================================================
	// reset release
	logic [1:0] rst_sync_ff;
	logic rst_n;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// =========================================================
	// clipping
	function automatic logic [RESULT_W-1:0] clip(input logic signed [31:0] v);
		logic signed [31:0] hi;
		logic signed [31:0] lo;
		hi = 32'sh007F_FFFF;
		lo = -32'sh0080_0000;
		if (v > hi) begin
			clip = `ADRD_FULL_POS;
		end else if (v < lo) begin
			clip = `ADRD_FULL_NEG;
		end else begin
			clip = v[RESULT_W-1:0];
		end
	endfunction

	// =========================================================
	// conversion state
	adrd_pkg::adrd_state_type state_ff, nxt_state;
	logic [6:0] mod_cnt_ff, nxt_mod_cnt;
	logic [15:0] conv_cnt_ff, nxt_conv_cnt;
	logic [1:0] cal_left_ff, nxt_cal_left;
	logic [RESULT_W-1:0] shreg_ff, nxt_shreg;
	logic [`ADRD_CNT_W-1:0] clks_ff, nxt_clks;
	logic sclk_d_ff, nxt_sclk_d;
	logic dout_ff, nxt_dout;
	logic cal_req_ff, nxt_cal_req;
	logic [7:0] hold_ff, nxt_hold;
	logic mod_ff, nxt_mod;
	logic rise, fall, conv_done;

	assign rise = shift_clk_i & ~sclk_d_ff;
	assign fall = ~shift_clk_i & sclk_d_ff;
	assign conv_done = (conv_cnt_ff == 16'(DECIM - 1)) &&
		(mod_cnt_ff == 7'(`ADRD_MOD_DIV - 1));

	always_comb begin
		nxt_state = state_ff;
		nxt_mod_cnt = mod_cnt_ff + 7'h01;
		nxt_mod = (mod_cnt_ff < 7'h40);
		nxt_conv_cnt = conv_cnt_ff;
		nxt_cal_left = cal_left_ff;
		nxt_shreg = shreg_ff;
		nxt_clks = clks_ff;
		nxt_sclk_d = shift_clk_i;
		nxt_dout = dout_ff;
		nxt_cal_req = cal_req_ff;
		nxt_hold = hold_ff;
		if (mod_cnt_ff == 7'(`ADRD_MOD_DIV - 1)) begin
			nxt_conv_cnt = conv_cnt_ff + 16'h0001;
		end
		if (rise && state_ff != adrd_pkg::ST_SLEEP) begin
			if (clks_ff < 6'(RESULT_W)) begin
				nxt_dout = shreg_ff[RESULT_W-1];
				nxt_shreg = {shreg_ff[RESULT_W-2:0], 1'b0};
			end else if (clks_ff == 6'(`ADRD_FORCE_HIGH_CLKS - 1)) begin
				nxt_dout = 1'b1;
			end
			if (clks_ff != 6'h3F) begin
				nxt_clks = clks_ff + 6'h01;
			end
		end
		if (fall && clks_ff == 6'(`ADRD_CAL_CLKS) && state_ff == adrd_pkg::ST_CONVERT) begin
			nxt_state = adrd_pkg::ST_CAL;
			nxt_cal_left = 2'(`ADRD_CAL_CONVS);
			nxt_conv_cnt = 16'h0000;
			nxt_mod_cnt = 7'h00;
			nxt_dout = 1'b1;
		end
		if (shift_clk_i && state_ff == adrd_pkg::ST_CONVERT && clks_ff != 6'h00) begin
			nxt_hold = (hold_ff == 8'(SLEEP_HOLD)) ? hold_ff : hold_ff + 8'h01;
		end else begin
			nxt_hold = 8'h00;
		end
		case (state_ff)
			adrd_pkg::ST_CAL: begin
				nxt_dout = 1'b1;
				if (conv_done) begin
					nxt_conv_cnt = 16'h0000;
					if (cal_left_ff == 2'h1) begin
						nxt_state = adrd_pkg::ST_CONVERT;
						nxt_shreg = clip(sample_i);
						nxt_dout = 1'b0;
						nxt_clks = '0;
					end
					nxt_cal_left = cal_left_ff - 2'h1;
				end
			end
			adrd_pkg::ST_CONVERT: begin
				if (hold_ff == 8'(SLEEP_HOLD)) begin
					nxt_state = adrd_pkg::ST_SLEEP;
					nxt_dout = 1'b1;
					nxt_cal_req = (clks_ff == 6'(`ADRD_FORCE_HIGH_CLKS));
				end else if (conv_done && nxt_state == adrd_pkg::ST_CONVERT) begin
					nxt_conv_cnt = 16'h0000;
					nxt_shreg = clip(sample_i);
					nxt_dout = 1'b0;
					nxt_clks = '0;
				end
			end
			adrd_pkg::ST_SLEEP: begin
				nxt_dout = 1'b1;
				nxt_mod_cnt = 7'h00;
				nxt_conv_cnt = 16'h0000;
				if (!shift_clk_i) begin
					nxt_clks = '0;
					nxt_cal_req = 1'b0;
					nxt_state = cal_req_ff ? adrd_pkg::ST_CAL : adrd_pkg::ST_CONVERT;
					nxt_cal_left = cal_req_ff ? 2'(`ADRD_CAL_CONVS) : 2'h1;
				end
			end
			default: nxt_state = adrd_pkg::ST_CAL;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= adrd_pkg::ST_CAL;
			mod_cnt_ff <= 7'h00;
			conv_cnt_ff <= 16'h0000;
			cal_left_ff <= 2'(`ADRD_CAL_CONVS);
			shreg_ff <= '0;
			clks_ff <= '0;
			sclk_d_ff <= 1'b0;
			dout_ff <= 1'b1;
			cal_req_ff <= 1'b0;
			hold_ff <= 8'h00;
			mod_ff <= 1'b0;
		end else if (ce_i) begin
			state_ff <= nxt_state;
			mod_cnt_ff <= nxt_mod_cnt;
			conv_cnt_ff <= nxt_conv_cnt;
			cal_left_ff <= nxt_cal_left;
			shreg_ff <= nxt_shreg;
			clks_ff <= nxt_clks;
			sclk_d_ff <= nxt_sclk_d;
			dout_ff <= nxt_dout;
			cal_req_ff <= nxt_cal_req;
			hold_ff <= nxt_hold;
			mod_ff <= nxt_mod;
		end
	end

	// =========================================================
	// outputs
	logic sleep_ff, nxt_sleep, cal_ff, nxt_cal;
	always_comb begin
		nxt_sleep = (nxt_state == adrd_pkg::ST_SLEEP);
		nxt_cal = (nxt_state == adrd_pkg::ST_CAL);
	end
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sleep_ff <= 1'b0;
			cal_ff <= 1'b1;
		end else if (ce_i) begin
			sleep_ff <= nxt_sleep;
			cal_ff <= nxt_cal;
		end
	end
	assign ready_data_out_o = dout_ff;
	assign sleeping_o = sleep_ff;
	assign calibrating_o = cal_ff;
	assign mod_phase_o = mod_ff;

	// =========================================================
	// checks
	property p_ready_low;
		@(posedge clk_i) disable iff (!rst_n)
		(ce_i && state_ff == adrd_pkg::ST_CONVERT && conv_done && hold_ff != 8'(SLEEP_HOLD) &&
		 !(fall && clks_ff == 6'(`ADRD_CAL_CLKS)))
		|=> !ready_data_out_o && clks_ff == '0;
	endproperty
	a_ready_low: assert property (p_ready_low) else $error("ready not signalled");

	property p_msb_first;
		@(posedge clk_i) disable iff (!rst_n)
		(ce_i && rise && clks_ff == '0 && state_ff == adrd_pkg::ST_CONVERT && !conv_done)
		|=> ready_data_out_o == $past(shreg_ff[RESULT_W-1]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("msb not first");

	property p_next_bit;
		@(posedge clk_i) disable iff (!rst_n)
		(ce_i && rise && clks_ff > '0 && clks_ff < 6'(RESULT_W) &&
		 state_ff == adrd_pkg::ST_CONVERT && !conv_done && hold_ff != 8'(SLEEP_HOLD))
		|=> shreg_ff == {$past(shreg_ff[RESULT_W-2:0]), 1'b0};
	endproperty
	a_next_bit: assert property (p_next_bit) else $error("shift did not advance");

	property p_force_high;
		@(posedge clk_i) disable iff (!rst_n)
		(ce_i && rise && clks_ff == 6'(`ADRD_FORCE_HIGH_CLKS - 1) &&
		 state_ff == adrd_pkg::ST_CONVERT && !conv_done)
		|=> ready_data_out_o;
	endproperty
	a_force_high: assert property (p_force_high) else $error("25th clock not high");

	property p_mod_wrap;
		@(posedge clk_i) disable iff (!rst_n)
		(ce_i && mod_cnt_ff == 7'h7F && state_ff != adrd_pkg::ST_SLEEP) |=> mod_cnt_ff == 7'h00;
	endproperty
	a_mod_wrap: assert property (p_mod_wrap) else $error("modulator period wrong");

	property p_cal_start;
		@(posedge clk_i) disable iff (!rst_n)
		(ce_i && fall && clks_ff == 6'(`ADRD_CAL_CLKS) && state_ff == adrd_pkg::ST_CONVERT &&
		 hold_ff != 8'(SLEEP_HOLD))
		|=> calibrating_o && ready_data_out_o;
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("calibration not started");

	property p_sleep_high;
		@(posedge clk_i) disable iff (!rst_n)
		(sleeping_o && state_ff == adrd_pkg::ST_SLEEP) |-> ready_data_out_o;
	endproperty
	a_sleep_high: assert property (p_sleep_high) else $error("pin low in sleep");

	property p_cal_pin_high;
		@(posedge clk_i) disable iff (!rst_n)
		(state_ff == adrd_pkg::ST_CAL && $past(state_ff) == adrd_pkg::ST_CAL) |-> ready_data_out_o;
	endproperty
	a_cal_pin_high: assert property (p_cal_pin_high) else $error("pin low in calibration");

	property p_hold_bit;
		@(posedge clk_i) disable iff (!rst_n)
		(ce_i && !rise && !conv_done && state_ff == adrd_pkg::ST_CONVERT &&
		 hold_ff != 8'(SLEEP_HOLD) && !fall)
		|=> $stable(ready_data_out_o);
	endproperty
	a_hold_bit: assert property (p_hold_bit) else $error("pin changed without cause");

	property p_conv_start;
		@(posedge clk_i) disable iff (!rst_n)
		(ce_i && state_ff == adrd_pkg::ST_CONVERT && conv_done && hold_ff != 8'(SLEEP_HOLD))
		|=> mod_cnt_ff == 7'h00 && conv_cnt_ff == 16'h0000;
	endproperty
	a_conv_start: assert property (p_conv_start) else $error("no restart at ready");

	property p_cal_end;
		@(posedge clk_i) disable iff (!rst_n)
		(ce_i && state_ff == adrd_pkg::ST_CAL && conv_done && cal_left_ff == 2'h1)
		|=> !ready_data_out_o && !calibrating_o;
	endproperty
	a_cal_end: assert property (p_cal_end) else $error("calibration end not signalled");

	property p_wake;
		@(posedge clk_i) disable iff (!rst_n)
		(ce_i && state_ff == adrd_pkg::ST_SLEEP && !shift_clk_i) |=> !sleeping_o;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on low shift clock");

	property p_ce_freeze;
		@(posedge clk_i) disable iff (!rst_n)
		!ce_i |=> $stable(ready_data_out_o) && $stable(state_ff) && $stable(mod_cnt_ff);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while disabled");
endmodule // adrd_port

// file: pkg/adrd_defs.svh
/*
 * timing counts and widths for the ready/data serial port of the converter.
 * assumes the includer works at the system clock rate on clk_i.
 */
`ifndef ADRD_DEFS_SVH
`define ADRD_DEFS_SVH

`define ADRD_RESULT_W 24
`define ADRD_CNT_W 6
`define ADRD_FORCE_HIGH_CLKS 25
`define ADRD_CAL_CLKS 26
`define ADRD_MOD_DIV 128
`define ADRD_DECIM 1280
`define ADRD_CAL_CONVS 2
`define ADRD_SLEEP_HOLD 64
`define ADRD_FULL_POS 24'h7F_FFFF
`define ADRD_FULL_NEG 24'h80_0000

`endif

// file: pkg/adrd_pkg.sv
/*
 * types for the ready/data serial port.
 * assumes adrd_defs.svh provides the numeric constants.
 */
package adrd_pkg;
	typedef enum logic [2:0] {
		ST_CAL,
		ST_CONVERT,
		ST_SLEEP
	} adrd_state_type;
endpackage
